// ==== core/ccr_bank.sv ====
// Charger control registers 0x00 to 0x03 behind an I2C target port.
// Notes on behaviour
// RL1 - All registers eight bits, bit 0 LSB.
// RL2 - Answer I2C target address 0x6B only.
// RL3 - Reg 0 bit 7 high-impedance enable, resets 0.
// RL4 - Reg 0 bit 6 limit-pin enable, resets 1.
// RL5 - Reg 0 bits 5:0 current code, reset 000100.
// RL6 - Effective limit is pin if enabled and lower, else register capped at 110000.
// RL7 - Detection done loads 500mA or 4900mA code.
// RL8 - Reg 1 reads 00000110, writes discarded.
// RL9 - Reg 2 bit 7 sampling permit, resets 0.
// RL10 - Reg 2 bit 5 boost frequency, locked during OTG.
// RL11 - Reg 2 reserved bits writable, reset 100/0.
// RL12 - Reg 2 bit 1 forces source detection.
// RL13 - Reg 2 bit 0 enables detection on plug-in.
// RL14 - Reg 3 bit 7 battery load enable.
// RL15 - Reg 3 bit 6 watchdog restart, self-clearing.
// RL16 - Reg 3 bit 5 OTG, beats charge enable.
// RL17 - Charge needs bit 4 set, pin low.
// RL18 - Reg 3 bits 3:1 system voltage, reset 101.
// RL19 - Reg 3 bit 0 boost-exit threshold, resets 0.
// RL20 - Undefined register address gets NACK, idle.
// RL21 - Multi-byte writes advance register address.
// RL22 - Watchdog expiry restores only watchdog fields.
// RL23 - Power-on and register reset restore everything.
`timescale 1ns/10ps
`include "ccr_consts.svh"

module ccr_bank (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // I2C pins, open drain
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe_n,
  // Device events and pins
  input  wire ccr_pkg::ccr_event_t events,
  input  wire logic              source_select,
  input  wire logic              charge_enable_pin_n,
  input  wire logic [5:0]        current_limit_pin_code,
  // Control outputs
  output ccr_pkg::ccr_ctrl_t     ctrl
);
  import ccr_pkg::*;

  logic [7:0] rst0, rst2, rst3;
  assign rst0 = `CCR_RST_INPUT_LIMIT;
  assign rst2 = `CCR_RST_SAMPLE_DET;
  assign rst3 = `CCR_RST_CHG_BOOST;

  // Register fields.
  logic       high_impedance_enable;
  logic       limit_pin_enable;
  logic [5:0] input_current_limit_code;
  logic       sampling_permit;
  logic       reserved_bit6;
  logic       boost_frequency_select;
  logic [2:0] reserved_bits42;
  logic       force_source_detection;
  logic       auto_source_detection_enable;
  logic       battery_load_enable;
  logic       watchdog_restart;
  logic       otg_boost_enable;
  logic       charge_enable_bit;
  logic [2:0] minimum_system_voltage_code;
  logic       boost_exit_threshold_select;
  // Target port state.
  ccr_state_t state;
  logic       scl_q;
  logic       sda_q;
  logic [7:0] shift;
  logic [3:0] count;
  logic       read_dir;
  logic       host_ack;
  logic [7:0] ptr;
  logic       wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  logic       start_seen;
  logic       stop_seen;
  logic       scl_rise;
  logic       scl_fall;
  logic       full_reset;
  logic       wd_reset;
  logic [7:0] rd_data;
  logic [7:0] input_limit_control;
  logic [7:0] reserved_fixed;
  logic [7:0] sampling_detection_control;
  logic [7:0] charge_boost_control;

  assign full_reset = rst | events.register_reset;                         // [RL23]
  assign wd_reset   = events.watchdog_expired;
  assign sda_out    = 1'b0;
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;
  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  // Read view of the bank; each register is one full byte.
  assign input_limit_control        = {high_impedance_enable, limit_pin_enable,
                                       input_current_limit_code};       // [RL1]
  assign reserved_fixed             = `CCR_RST_FIXED;                 // [RL8]
  assign sampling_detection_control = {sampling_permit, reserved_bit6, boost_frequency_select,
                                       reserved_bits42, force_source_detection,
                                       auto_source_detection_enable};
  assign charge_boost_control       = {battery_load_enable, watchdog_restart, otg_boost_enable,
                                       charge_enable_bit, minimum_system_voltage_code,
                                       boost_exit_threshold_select};

  always_comb begin
    unique case (ptr)
      `CCR_OFF_INPUT_LIMIT: rd_data = input_limit_control;
      `CCR_OFF_FIXED:       rd_data = reserved_fixed;
      `CCR_OFF_SAMPLE_DET:  rd_data = sampling_detection_control;
      `CCR_OFF_CHG_BOOST:   rd_data = charge_boost_control;
      default:              rd_data = `CCR_UNMAPPED_READ;
    endcase
  end

  // Pins are sampled once; the previous sample gives edges and bus conditions.
  always_ff @(posedge clock) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // Target port sequencer.
  always_ff @(posedge clock) begin
    if (rst) begin
      state    <= CCR_IDLE;
      shift    <= 8'h00;
      count    <= 4'h0;
      read_dir <= 1'b0;
      host_ack <= 1'b0;
      ptr      <= 8'h00;
      sda_oe_n <= 1'b1;
      wr_stb   <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_seen) begin
        state    <= CCR_DEV;
        count    <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_seen) begin
        state    <= CCR_IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (state == CCR_DEV || state == CCR_PTR || state == CCR_WR) begin
          shift <= {shift[6:0], sda_in};
          count <= count + 4'h1;
        end else if (state == CCR_RD_ACK) begin
          host_ack <= ~sda_in;
        end
      end else if (scl_fall) begin
        unique case (state)
          CCR_DEV: begin
            if (count == 4'h8) begin
              if (shift[7:1] == `CCR_TARGET_ADDR) begin                   // [RL2]
                read_dir <= shift[0];
                sda_oe_n <= 1'b0;
                state    <= CCR_ACK_DEV;
              end else begin
                state <= CCR_IDLE;
              end
            end
          end
          CCR_PTR: begin
            if (count == 4'h8) begin
              if (shift <= `CCR_LAST_OFFSET) begin
                ptr      <= shift;
                sda_oe_n <= 1'b0;
                state    <= CCR_ACK_PTR;
              end else begin
                state <= CCR_IDLE;                                         // [RL20]
              end
            end
          end
          CCR_WR: begin
            if (count == 4'h8) begin
              if (ptr <= `CCR_LAST_OFFSET) begin
                wr_stb   <= 1'b1;
                wr_addr  <= ptr;
                wr_data  <= shift;
                ptr      <= ptr + 8'h01;                                   // [RL21]
                sda_oe_n <= 1'b0;
                state    <= CCR_ACK_WR;
              end else begin
                state <= CCR_IDLE;                                         // [RL20]
              end
            end
          end
          CCR_ACK_DEV: begin
            count <= (read_dir) ? 4'h1 : 4'h0;
            if (read_dir) begin
              shift    <= rd_data;
              sda_oe_n <= rd_data[7];
              ptr      <= ptr + 8'h01;
              state    <= CCR_RD;
            end else begin
              sda_oe_n <= 1'b1;
              state    <= CCR_PTR;
            end
          end
          CCR_ACK_PTR, CCR_ACK_WR: begin
            sda_oe_n <= 1'b1;
            count    <= 4'h0;
            state    <= CCR_WR;
          end
          CCR_RD: begin
            if (count == 4'h8) begin
              sda_oe_n <= 1'b1;
              state    <= CCR_RD_ACK;
            end else begin
              sda_oe_n <= shift[6];
              shift    <= {shift[6:0], 1'b0};
              count    <= count + 4'h1;
            end
          end
          CCR_RD_ACK: begin
            if (host_ack) begin
              shift    <= rd_data;
              sda_oe_n <= rd_data[7];
              ptr      <= ptr + 8'h01;
              count    <= 4'h1;
              state    <= CCR_RD;
            end else begin
              state <= CCR_IDLE;
            end
          end
          default: begin
            sda_oe_n <= 1'b1;
            state    <= CCR_IDLE;
          end
        endcase
      end
    end
  end

  // Register 0x00. Detection completion outranks a host write in the same cycle.
  always_ff @(posedge clock) begin
    if (full_reset) begin
      high_impedance_enable    <= rst0[`CCR_BIT_HIZ];                      // [RL3]
      limit_pin_enable         <= rst0[`CCR_BIT_LIMIT_PIN];                // [RL4]
      input_current_limit_code <= rst0[5:0];                               // [RL5]
    end else begin
      if (wd_reset) begin
        high_impedance_enable <= rst0[`CCR_BIT_HIZ];                       // [RL22]
        limit_pin_enable      <= rst0[`CCR_BIT_LIMIT_PIN];
      end else if (wr_stb && wr_addr == `CCR_OFF_INPUT_LIMIT) begin
        high_impedance_enable <= wr_data[`CCR_BIT_HIZ];
        limit_pin_enable      <= wr_data[`CCR_BIT_LIMIT_PIN];
      end
      if (events.detection_done) begin
        input_current_limit_code <= source_select ? `CCR_CODE_LOW_SOURCE
                                                  : `CCR_CODE_HI_SOURCE;   // [RL7]
      end else if (wr_stb && wr_addr == `CCR_OFF_INPUT_LIMIT) begin
        input_current_limit_code <= wr_data[5:0];                          // [RL5]
      end
    end
  end

  // Register 0x02. The forced-detection bit stays set until detection finishes, the watchdog expires or a reset.
  always_ff @(posedge clock) begin
    if (full_reset) begin
      sampling_permit              <= rst2[`CCR_BIT_PERMIT];               // [RL9]
      reserved_bit6                <= rst2[`CCR_BIT_RSV6];                 // [RL11]
      boost_frequency_select       <= rst2[`CCR_BIT_BOOST_FREQUENCY_SELECT];
      reserved_bits42              <= rst2[4:2];                           // [RL11]
      force_source_detection       <= rst2[`CCR_BIT_FORCE_DET];
      auto_source_detection_enable <= rst2[`CCR_BIT_AUTO_DET];             // [RL13]
    end else begin
      if (wd_reset) begin
        sampling_permit        <= rst2[`CCR_BIT_PERMIT];                   // [RL22]
        reserved_bit6          <= rst2[`CCR_BIT_RSV6];
        force_source_detection <= rst2[`CCR_BIT_FORCE_DET];
      end else if (wr_stb && wr_addr == `CCR_OFF_SAMPLE_DET) begin
        sampling_permit <= wr_data[`CCR_BIT_PERMIT];
        reserved_bit6   <= wr_data[`CCR_BIT_RSV6];
        if (wr_data[`CCR_BIT_FORCE_DET]) begin
          force_source_detection <= 1'b1;                                  // [RL12]
        end else if (events.detection_done) begin
          force_source_detection <= 1'b0;
        end
      end else if (events.detection_done) begin
        force_source_detection <= 1'b0;
      end
      if (wr_stb && wr_addr == `CCR_OFF_SAMPLE_DET) begin
        reserved_bits42              <= wr_data[4:2];
        auto_source_detection_enable <= wr_data[`CCR_BIT_AUTO_DET];
        if (!otg_boost_enable) begin
          boost_frequency_select <= wr_data[`CCR_BIT_BOOST_FREQUENCY_SELECT];          // [RL10]
        end
      end
    end
  end

  // Register 0x03. A restart request set by the host wins over its own clearing.
  always_ff @(posedge clock) begin
    if (full_reset) begin
      battery_load_enable         <= rst3[`CCR_BIT_LOAD];                  // [RL14]
      watchdog_restart            <= rst3[`CCR_BIT_WD_RESTART];
      otg_boost_enable            <= rst3[`CCR_BIT_OTG];
      charge_enable_bit           <= rst3[`CCR_BIT_CHARGE];
      minimum_system_voltage_code <= rst3[3:1];                            // [RL18]
      boost_exit_threshold_select <= rst3[`CCR_BIT_EXIT_SEL];              // [RL19]
    end else begin
      if (wd_reset) begin
        battery_load_enable         <= rst3[`CCR_BIT_LOAD];                // [RL22]
        watchdog_restart            <= rst3[`CCR_BIT_WD_RESTART];
        otg_boost_enable            <= rst3[`CCR_BIT_OTG];
        charge_enable_bit           <= rst3[`CCR_BIT_CHARGE];
        boost_exit_threshold_select <= rst3[`CCR_BIT_EXIT_SEL];
      end else if (wr_stb && wr_addr == `CCR_OFF_CHG_BOOST) begin
        battery_load_enable         <= wr_data[`CCR_BIT_LOAD];
        otg_boost_enable            <= wr_data[`CCR_BIT_OTG];
        charge_enable_bit           <= wr_data[`CCR_BIT_CHARGE];
        boost_exit_threshold_select <= wr_data[`CCR_BIT_EXIT_SEL];
        if (wr_data[`CCR_BIT_WD_RESTART]) begin
          watchdog_restart <= 1'b1;                                        // [RL15]
        end else if (events.watchdog_restarted) begin
          watchdog_restart <= 1'b0;
        end
      end else if (events.watchdog_restarted) begin
        watchdog_restart <= 1'b0;                                          // [RL15]
      end
      if (wr_stb && wr_addr == `CCR_OFF_CHG_BOOST) begin
        minimum_system_voltage_code <= wr_data[3:1];                       // [RL18]
      end
    end
  end

  // Outputs are registered, so each follows its field one cycle later.
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= '0;
    end else begin
      ctrl.high_impedance_enable <= high_impedance_enable;
      if (limit_pin_enable && current_limit_pin_code < input_current_limit_code) begin
        ctrl.effective_limit_code <= current_limit_pin_code;               // [RL6]
      end else if (input_current_limit_code > `CCR_CODE_MAX) begin
        ctrl.effective_limit_code <= `CCR_CODE_MAX;
      end else begin
        ctrl.effective_limit_code <= input_current_limit_code;
      end
      ctrl.sampling_permit             <= sampling_permit;
      ctrl.boost_frequency_select      <= boost_frequency_select;
      ctrl.force_source_detection      <= force_source_detection;
      ctrl.auto_detection_start        <= events.vbus_plugged
                                          & auto_source_detection_enable; // [RL13]
      ctrl.battery_load_enable         <= battery_load_enable;
      ctrl.watchdog_restart            <= watchdog_restart;
      ctrl.otg_boost_enable            <= otg_boost_enable;
      ctrl.charging_active             <= charge_enable_bit & ~charge_enable_pin_n
                                          & ~otg_boost_enable;            // [RL16] [RL17]
      ctrl.minimum_system_voltage_code <= minimum_system_voltage_code;
      ctrl.boost_exit_threshold_select <= boost_exit_threshold_select;
    end
  end

endmodule

// ==== core/ccr_consts.svh ====
// Register offsets, field positions, reset values and codes for the charger control bank.
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

`define CCR_TARGET_ADDR     7'h6B
`define CCR_LAST_OFFSET     8'h03

`define CCR_OFF_INPUT_LIMIT 8'h00
`define CCR_OFF_FIXED       8'h01
`define CCR_OFF_SAMPLE_DET  8'h02
`define CCR_OFF_CHG_BOOST   8'h03

`define CCR_RST_INPUT_LIMIT 8'h44
`define CCR_RST_FIXED       8'h06
`define CCR_RST_SAMPLE_DET  8'h11
`define CCR_RST_CHG_BOOST   8'h1A

`define CCR_BIT_HIZ         7
`define CCR_BIT_LIMIT_PIN   6
`define CCR_BIT_PERMIT      7
`define CCR_BIT_RSV6        6
`define CCR_BIT_BOOST_FREQUENCY_SELECT  5
`define CCR_BIT_FORCE_DET   1
`define CCR_BIT_AUTO_DET    0
`define CCR_BIT_LOAD        7
`define CCR_BIT_WD_RESTART  6
`define CCR_BIT_OTG         5
`define CCR_BIT_CHARGE      4
`define CCR_BIT_EXIT_SEL    0

`define CCR_CODE_LOW_SOURCE 6'h04
`define CCR_CODE_HI_SOURCE  6'h30
`define CCR_CODE_MAX        6'h30
`define CCR_UNMAPPED_READ   8'hFF

`endif

// ==== core/ccr_pkg.sv ====
// Types shared by the charger control register bank.
package ccr_pkg;

  typedef enum logic [3:0] {
    CCR_IDLE    = 4'b0000,
    CCR_DEV     = 4'b0001,
    CCR_ACK_DEV = 4'b0010,
    CCR_PTR     = 4'b0011,
    CCR_ACK_PTR = 4'b0100,
    CCR_WR      = 4'b0101,
    CCR_ACK_WR  = 4'b0110,
    CCR_RD      = 4'b0111,
    CCR_RD_ACK  = 4'b1000
  } ccr_state_t;

  typedef struct packed {
    logic register_reset;
    logic watchdog_expired;
    logic watchdog_restarted;
    logic detection_done;
    logic vbus_plugged;
  } ccr_event_t;

  typedef struct packed {
    logic       high_impedance_enable;
    logic [5:0] effective_limit_code;
    logic       sampling_permit;
    logic       boost_frequency_select;
    logic       force_source_detection;
    logic       auto_detection_start;
    logic       battery_load_enable;
    logic       watchdog_restart;
    logic       otg_boost_enable;
    logic       charging_active;
    logic [2:0] minimum_system_voltage_code;
    logic       boost_exit_threshold_select;
  } ccr_ctrl_t;

endpackage

// ==== dv/ccr_checker.sv ====
// Concurrent checks on the ports of the charger control bank.
`timescale 1ns/10ps
module ccr_checker (
  // Clock and reset
  input wire logic                clock,
  input wire logic                rst,
  // I2C pins
  input wire logic                scl_in,
  input wire logic                sda_in,
  input wire logic                sda_out,
  input wire logic                sda_oe_n,
  // Events and pins
  input wire ccr_pkg::ccr_event_t events,
  input wire logic                source_select,
  input wire logic                charge_enable_pin_n,
  input wire logic [5:0]          current_limit_pin_code,
  // Controls
  input wire ccr_pkg::ccr_ctrl_t  ctrl
);
  import ccr_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_sda_low_only: assert property (sda_out == 1'b0)
    else $error("sda_out driven high");
  // The pin may only move one clock after a falling SCL, never while SCL is high.
  a_oe_after_fall: assert property ($changed(sda_oe_n) |-> !$past(scl_in) && $past(scl_in, 2))
    else $error("sda_oe_n moved outside the low phase of scl");
  a_charge_pin: assert property (ctrl.charging_active |-> !$past(charge_enable_pin_n))
    else $error("charging while the pin is high");
  a_otg_wins: assert property (ctrl.otg_boost_enable |-> !ctrl.charging_active)
    else $error("charging while boost is on");
  a_detect_code: assert property (events.detection_done && source_select |->
    ##2 (ctrl.effective_limit_code <= 6'h04))
    else $error("detection did not load the low-source code");
  a_force_clear: assert property (events.detection_done |-> ##2 !ctrl.force_source_detection)
    else $error("forced detection not cleared");
  a_auto_start: assert property (ctrl.auto_detection_start |-> $past(events.vbus_plugged))
    else $error("detection start without plug-in");
  a_wd_clear: assert property (events.watchdog_restarted |-> ##2 !ctrl.watchdog_restart)
    else $error("restart bit not cleared");
  a_regreset_vals: assert property (events.register_reset |-> ##2
    (ctrl.minimum_system_voltage_code == 3'h5 && !ctrl.otg_boost_enable))
    else $error("register reset left fields changed");
  a_wd_expiry: assert property (events.watchdog_expired |-> ##2
    (!ctrl.battery_load_enable && !ctrl.sampling_permit && !ctrl.high_impedance_enable))
    else $error("watchdog fields not restored");
endmodule

bind ccr_bank ccr_checker ccr_checker_i (.clock, .rst, .scl_in, .sda_in, .sda_out, .sda_oe_n,
  .events, .source_select, .charge_enable_pin_n, .current_limit_pin_code, .ctrl);

// ==== dv/ccr_host.sv ====
// I2C bus master model standing in for the host controller.
`timescale 1ns/10ps
module ccr_host (
  // Clock
  input wire logic clock,
  // Bus, sda_m high means released to the pull-up
  input wire logic sda,
  output logic     scl,
  output logic     sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Data moves only while SCL is low, so the target never sees a false frame edge.
  task automatic sbit(input logic b, output logic r);
    sda_m <= b;
    tick(3);
    scl <= 1'b1;
    tick(4);
    r = sda;
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic start();
    sda_m <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(3);
    sda_m <= 1'b0;
    tick(3);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_m <= 1'b1;
    tick(3);
  endtask
  task automatic xbyte(input logic [7:0] d, input logic ma, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) sbit(d[i], q[i]);
    sbit(ma, a);
  endtask
  task automatic xact(input logic [6:0] dev, input logic rd, input logic [7:0] ptr, input int n,
                      input logic [31:0] wd, output logic [31:0] q, output logic [7:0] acks);
    logic [7:0] b;
    q = '0;
    acks = '1;
    start();
    xbyte({dev, 1'b0}, 1'b1, b, acks[0]);
    xbyte(ptr, 1'b1, b, acks[1]);
    if (rd) begin
      start();
      xbyte({dev, 1'b1}, 1'b1, b, acks[2]);
    end
    for (int i = 0; i < n; i++) begin
      xbyte(rd ? 8'hFF : wd[8*i +: 8], rd ? (i == n - 1) : 1'b1, b, acks[3+i]);
      if (rd) q[8*i +: 8] = b;
    end
    stop();
  endtask
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the charger control register bank.
`timescale 1ns/10ps
module testbench;
  import ccr_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        scl;
  logic        sda_m;
  wire logic   sda;
  logic        sda_out;
  logic        sda_oe_n;
  ccr_event_t  ev = '0;
  logic        src_sel = 1'b0;
  logic        pin_n = 1'b0;
  logic [5:0]  pin_code = 6'h30;
  ccr_ctrl_t   ctrl;
  logic [7:0]  m [4];
  logic [31:0] q;
  logic [7:0]  acks;
  int          bad_count = 0;
  int          check_count = 0;
  integer      seed = 32'hFED662AC;

  always #10 clock = ~clock;
  assign sda = sda_m & (sda_oe_n | sda_out);

  ccr_host ccr_host_i (.clock(clock), .sda(sda), .scl(scl), .sda_m(sda_m));
  ccr_bank ccr_bank_i (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .events(ev), .source_select(src_sel), .charge_enable_pin_n(pin_n),
    .current_limit_pin_code(pin_code), .ctrl(ctrl));

  task automatic complete_run();
    $display("checks=%0d errors=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic mwr(input int p, input logic [7:0] d);
    logic [7:0] o;
    o = m[p];
    if (p == 2) m[2] = m[3][5] ? {d[7:6], m[2][5], d[4:0]} : d;
    else if (p != 1) m[p] = d;
    // Writing 0 leaves a pending request set; its completion event, watchdog expiry or register reset clears it.
    if (p == 2) m[2][1] = m[2][1] | o[1];
    if (p == 3) m[3][6] = m[3][6] | o[6];
  endtask
  task automatic hw(input logic [6:0] dev, input int p, input int n, input logic [31:0] d);
    logic [7:0] e;
    e = 8'hFF;
    if (dev == 7'h6B) begin
      e[1:0] = {p > 3, 1'b0};
      for (int i = 0; i < n; i++) begin
        e[3+i] = (p + i > 3);
        if (p + i < 4) mwr(p + i, d[8*i +: 8]);
      end
    end
    ccr_host_i.xact(dev, 1'b0, p[7:0], n, d, q, acks);
    chk(acks, e);
  endtask
  task automatic hr(input int p, input int n);
    ccr_host_i.xact(7'h6B, 1'b1, p[7:0], n, 32'h0, q, acks);
    for (int i = 0; i < n; i++) chk(q[8*i +: 8], (p + i < 4) ? m[p+i] : 8'hFF);
  endtask
  // Reads the whole bank back, then compares every control output with the model.
  task automatic cmp_all();
    int        c;
    ccr_ctrl_t x;
    hr(0, 4);
    c = (m[0][5:0] > 6'h30) ? 48 : m[0][5:0];
    if (m[0][6] && pin_code < c) c = pin_code;
    x = {m[0][7], c[5:0], m[2][7], m[2][5], m[2][1], 1'b0, m[3][7:5],
         m[3][4] & ~pin_n & ~m[3][5], m[3][3:0]};
    #1;
    chk(ctrl, x);
  endtask
  task automatic pulse(input int i);
    @(posedge clock);
    ev <= ccr_event_t'(5'h01 << i);
    @(posedge clock);
    ev <= '0;
    repeat (3) @(posedge clock);
  endtask

  initial begin
    #2_000_000;
    bad_count++;
    complete_run();
  end

  initial begin
    m = '{8'h44, 8'h06, 8'h11, 8'h1A};
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    cmp_all();
    hr(3, 2);
    for (int k = 0; k < 6; k++) begin
      @(posedge clock);
      pin_code <= 6'(($random(seed) & 32'h7FFFFFFF) % 49);
      pin_n <= 1'($random(seed));
      hw(7'h6B, 0, 4, $random(seed));
      cmp_all();
    end
    hw(7'h6A, 0, 1, 32'hFF);
    hw(7'h6B, 4, 1, 32'h00);
    hw(7'h6B, 2, 3, $random(seed));
    cmp_all();
    for (int s = 0; s < 2; s++) begin
      hw(7'h6B, 2, 1, 32'h06 | s);
      @(posedge clock);
      ev.vbus_plugged <= 1'b1;
      @(posedge clock);
      ev.vbus_plugged <= 1'b0;
      #1;
      chk(ctrl.auto_detection_start, m[2][0]);
      src_sel <= s[0];
      pulse(1);
      m[0][5:0] = s[0] ? 6'h04 : 6'h30;
      m[2][1] = 1'b0;
      cmp_all();
    end
    hw(7'h6B, 3, 1, 32'h5B);
    cmp_all();
    pulse(2);
    m[3][6] = 1'b0;
    cmp_all();
    hw(7'h6B, 0, 4, 32'hFFFFFFFF);
    hw(7'h6B, 2, 1, 32'h00);
    cmp_all();
    pulse(3);
    m[0][7:6] = 2'b01;
    m[2] = {2'b00, m[2][5:2], 1'b0, m[2][0]};
    m[3] = {4'b0001, m[3][3:1], 1'b0};
    cmp_all();
    pulse(4);
    m = '{8'h44, 8'h06, 8'h11, 8'h1A};
    cmp_all();
    complete_run();
  end
endmodule
